// file: logic/lapc_defs.svh
// Purpose: Constants of the line audio and power control register bank.
// Assumes: APB byte addresses are four times the register index.
// Notes: Definitions only.
`ifndef LAPC_DEFS_SVH
`define LAPC_DEFS_SVH

// ****************************************************************
// Bus geometry
// ****************************************************************
`define LAPC_AW 8
`define LAPC_DW 32
`define LAPC_RW 8
`define LAPC_ZERO_PAD 24'h00_0000
`define LAPC_RDATA_IDLE 32'h0000_0000
`define LAPC_ALIGN_OK 2'h0

// ****************************************************************
// Register indexes (byte address is index times four)
// ****************************************************************
`define LAPC_IDX_AUDIO 6'h09
`define LAPC_IDX_IMPED 6'h0A
`define LAPC_IDX_HYBRID 6'h0B
`define LAPC_IDX_POWER 6'h0E

// ****************************************************************
// Writable bit masks; reserved bits are zero here
// ****************************************************************
`define LAPC_MASK_AUDIO 8'hFF
`define LAPC_MASK_IMPED 8'h3F
`define LAPC_MASK_HYBRID 8'h77
`define LAPC_MASK_POWER 8'h1B

// ****************************************************************
// Reset values
// ****************************************************************
`define LAPC_RST_AUDIO 8'h00
`define LAPC_RST_IMPED 8'h00
`define LAPC_RST_HYBRID 8'h00
`define LAPC_RST_POWER 8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define LAPC_RX_BYPASS_BIT 7
`define LAPC_TX_BYPASS_BIT 6
`define LAPC_TX_MUTE_BIT 5
`define LAPC_RX_MUTE_BIT 4
`define LAPC_TX_GAIN_RANGE 3:2
`define LAPC_RX_GAIN_RANGE 1:0
`define LAPC_CAP_RANGE 5:4
`define LAPC_SYNTH_EN_BIT 3
`define LAPC_PROFILE_RANGE 2:0
`define LAPC_METER_RANGE 6:4
`define LAPC_AUDIO_HYB_RANGE 2:0
`define LAPC_CONV_OFF_BIT 4
`define LAPC_PLL_FREE_BIT 3
`define LAPC_BIAS_OFF_BIT 1
`define LAPC_LINE_OFF_BIT 0

`endif

// file: logic/lapc_pkg.sv
// Purpose: Types shared by the line audio and power control bank.
// Assumes: Codes match the register field encodings.
// Notes: Constants live in lapc_defs.svh.
package lapc_pkg;

	// ****************************************************************
	// Field encodings
	// ****************************************************************
	typedef enum logic [1:0] {
		LAPC_GAIN_0DB = 2'h0,
		LAPC_GAIN_M3P5 = 2'h1,
		LAPC_GAIN_P3P5 = 2'h2,
		LAPC_GAIN_MUTE = 2'h3
	} lapc_gain_type;

	typedef enum logic [1:0] {
		LAPC_CAP_OFF = 2'h0,
		LAPC_CAP_4N7 = 2'h1,
		LAPC_CAP_10N = 2'h2,
		LAPC_CAP_RSVD = 2'h3
	} lapc_cap_type;

	typedef enum logic [2:0] {
		LAPC_HYB_STEP_MAX = 3'h0,
		LAPC_HYB_STEP_UNITY = 3'h3,
		LAPC_HYB_STEP_MIN = 3'h6,
		LAPC_HYB_OFF = 3'h7
	} lapc_hybrid_type;

	typedef logic [7:0] lapc_reg_type;

endpackage : lapc_pkg

// file: logic/lapc_hybrid_dec.sv
// Purpose: Decode a three-bit hybrid adjustment code.
// Assumes: Code 7 means the hybrid is switched off.
// Notes: Purely combinational; the caller registers the result.
module lapc_hybrid_dec
	import lapc_pkg::*;
(
	input wire logic [2:0] code,
	output logic hybrid_on,
	output logic [2:0] step
);

	// ****************************************************************
	// Decode
	// ****************************************************************
	// Off code parks the step at the top of scale so nothing toggles
	always_comb begin
		hybrid_on = (code != LAPC_HYB_OFF);
		step = hybrid_on ? code : LAPC_HYB_STEP_MAX;
	end

endmodule : lapc_hybrid_dec

// file: logic/lapc_regs.sv
// Purpose: APB register bank for audio path, impedance, hybrid and power overrides.
// Assumes: pclk at 10 MHz, presetn asynchronous active low, auto_* inputs on pclk.
// Notes: Zero wait state slave; every output comes from a flip-flop.
//
// Contract
// - Audio bit 7 set bypasses the receive high-pass filter, clear keeps it.
// - Audio bit 6 set bypasses the transmit high-pass filter, clear keeps it.
// - Audio bit 5 set mutes the transmit signal digitally, clear passes it.
// - Audio bit 4 set mutes the receive signal digitally, clear passes it.
// - Transmit gain bits 3:2 give 0, -3.5, +3.5 dB; code 3 gives 0 dB and mutes.
// - Receive gain bits 1:0 give 0, -3.5, +3.5 dB; code 3 mutes the receive path.
// - Impedance bits 5:4 select no, 4.7 nF or 10 nF compensation; code 3 is reserved.
// - Impedance bit 3 enables two-wire impedance synthesis.
// - Impedance bits 2:0 pick one of eight termination profiles.
// - Hybrid bits 6:4 step metering hybrid from top to bottom; code 7 turns it off.
// - Hybrid bits 2:0 use the same scale for the audio hybrid; code 7 disables it.
// - Power bit 4 forces the converter off, else automatic control applies.
// - Power bit 3 forces the PLL into free-run, else free-run is automatic.
// - Power bit 1 forces the dc bias off, else automatic control applies.
// - Power bit 0 forces the line interface off, else automatic control applies.
//
// The APB interface to the registers was chosen for this implementation.
`include "lapc_defs.svh"

module lapc_regs (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`LAPC_AW-1:0] paddr,
	input wire logic [`LAPC_DW-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [`LAPC_DW-1:0] prdata,
	output logic pslverr,
	input wire logic auto_converter_on,
	input wire logic auto_pll_freerun,
	input wire logic auto_bias_on,
	input wire logic auto_line_interface_on,
	output logic receive_filter_bypass,
	output logic transmit_filter_bypass,
	output logic transmit_digital_mute,
	output logic receive_digital_mute,
	output lapc_pkg::lapc_gain_type analog_tx_gain_sel,
	output logic analog_tx_mute,
	output lapc_pkg::lapc_gain_type analog_rx_gain_sel,
	output logic analog_rx_mute,
	output lapc_pkg::lapc_cap_type line_cap_comp_sel,
	output logic impedance_synth_enable,
	output logic [2:0] impedance_profile_sel,
	output logic [7:0] impedance_profile_onehot,
	output logic metering_hybrid_on,
	output logic [2:0] metering_hybrid_adjust,
	output logic audio_hybrid_on,
	output logic [2:0] audio_hybrid_adjust,
	output logic converter_force_off,
	output logic pll_freerun_force,
	output logic bias_force_off,
	output logic line_interface_force_off,
	output logic converter_power_on,
	output logic pll_freerun,
	output logic bias_power_on,
	output logic line_interface_power_on
);
	import lapc_pkg::*;

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic pready_q, pready_d;
	logic [`LAPC_DW-1:0] prdata_q, prdata_d;
	logic pslverr_q, pslverr_d;
	lapc_reg_type audio_q, audio_d;
	lapc_reg_type imped_q, imped_d;
	lapc_reg_type hybrid_q, hybrid_d;
	lapc_reg_type power_q, power_d;
	logic [5:0] idx;
	logic hit_audio, hit_imped, hit_hybrid, hit_power;
	logic addr_err;
	logic setup_ph;
	logic wr_en;
	lapc_reg_type wbyte;
	lapc_reg_type rd_mux;
	logic meter_on_c, audio_on_c;
	logic [2:0] meter_step_c, audio_step_c;
	logic [7:0] onehot_c;
	logic rx_byp_q, rx_byp_d, tx_byp_q, tx_byp_d;
	logic tx_dmute_q, tx_dmute_d, rx_dmute_q, rx_dmute_d;
	lapc_gain_type tx_gain_q, tx_gain_d, rx_gain_q, rx_gain_d;
	logic tx_amute_q, tx_amute_d, rx_amute_q, rx_amute_d;
	lapc_cap_type cap_q, cap_d;
	logic synth_en_q, synth_en_d;
	logic [2:0] profile_q, profile_d;
	logic [7:0] onehot_q, onehot_d;
	logic meter_on_q, meter_on_d, audio_on_q, audio_on_d;
	logic [2:0] meter_step_q, meter_step_d, audio_step_q, audio_step_d;
	logic conv_off_q, conv_off_d, pll_force_q, pll_force_d;
	logic bias_off_q, bias_off_d, line_off_q, line_off_d;
	logic conv_on_q, conv_on_d, pll_free_q, pll_free_d;
	logic bias_on_q, bias_on_d, line_on_q, line_on_d;

	// ****************************************************************
	// Address decode
	// ****************************************************************
	// Byte address is four times the index; low bits must be zero
	always_comb begin
		idx = paddr[`LAPC_AW-1:2];
		hit_audio = (idx == `LAPC_IDX_AUDIO);
		hit_imped = (idx == `LAPC_IDX_IMPED);
		hit_hybrid = (idx == `LAPC_IDX_HYBRID);
		hit_power = (idx == `LAPC_IDX_POWER);
		addr_err = !(hit_audio || hit_imped || hit_hybrid || hit_power) ||
			(paddr[1:0] != `LAPC_ALIGN_OK);
		setup_ph = psel && !penable;
		wbyte = pwdata[`LAPC_RW-1:0];
		// Write lands only at the edge that completes the access phase
		wr_en = psel && penable && pready_q && pwrite && !pslverr_q && pstrb[0];
	end

	// Read mux; reserved bits are cleared when stored, so they read as zero
	always_comb begin
		rd_mux = '0;
		if (hit_audio) begin
			rd_mux = audio_q;
		end else if (hit_imped) begin
			rd_mux = imped_q;
		end else if (hit_hybrid) begin
			rd_mux = hybrid_q;
		end else if (hit_power) begin
			rd_mux = power_q;
		end
	end

	// ****************************************************************
	// APB answer
	// ****************************************************************
	// Answer is prepared in the setup cycle so the access phase needs no wait
	always_comb begin
		pready_d = setup_ph;
		pslverr_d = setup_ph && addr_err;
		prdata_d = `LAPC_RDATA_IDLE;
		if (setup_ph && !pwrite && !addr_err) begin
			prdata_d = {`LAPC_ZERO_PAD, rd_mux};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= `LAPC_RDATA_IDLE;
		end else begin
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
		end
	end

	// ****************************************************************
	// Register storage
	// ****************************************************************
	// Masks drop writes to reserved positions
	always_comb begin
		audio_d = audio_q;
		imped_d = imped_q;
		hybrid_d = hybrid_q;
		power_d = power_q;
		if (wr_en && hit_audio) begin
			audio_d = wbyte & `LAPC_MASK_AUDIO;
		end
		if (wr_en && hit_imped) begin
			imped_d = wbyte & `LAPC_MASK_IMPED;
		end
		if (wr_en && hit_hybrid) begin
			hybrid_d = wbyte & `LAPC_MASK_HYBRID;
		end
		if (wr_en && hit_power) begin
			power_d = wbyte & `LAPC_MASK_POWER;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			audio_q <= `LAPC_RST_AUDIO;
			imped_q <= `LAPC_RST_IMPED;
			hybrid_q <= `LAPC_RST_HYBRID;
			power_q <= `LAPC_RST_POWER;
		end else begin
			audio_q <= audio_d;
			imped_q <= imped_d;
			hybrid_q <= hybrid_d;
			power_q <= power_d;
		end
	end

	// ****************************************************************
	// Field decoders
	// ****************************************************************
	// One decoder per hybrid so both share the same scale exactly
	lapc_hybrid_dec u_meter_dec (
		.code(hybrid_q[`LAPC_METER_RANGE]),
		.hybrid_on(meter_on_c),
		.step(meter_step_c)
	);

	lapc_hybrid_dec u_audio_dec (
		.code(hybrid_q[`LAPC_AUDIO_HYB_RANGE]),
		.hybrid_on(audio_on_c),
		.step(audio_step_c)
	);

	// One select line per termination profile
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_profile
			assign onehot_c[gi] = (imped_q[`LAPC_PROFILE_RANGE] == 3'(gi));
		end
	endgenerate

	// ****************************************************************
	// Control outputs
	// ****************************************************************
	// Outputs lag the register by one cycle; the analog side cares little
	always_comb begin
		rx_byp_d = audio_q[`LAPC_RX_BYPASS_BIT];
		tx_byp_d = audio_q[`LAPC_TX_BYPASS_BIT];
		tx_dmute_d = audio_q[`LAPC_TX_MUTE_BIT];
		rx_dmute_d = audio_q[`LAPC_RX_MUTE_BIT];
		// Mute code holds the gain stage at 0 dB and mutes the path
		tx_amute_d = (audio_q[`LAPC_TX_GAIN_RANGE] == LAPC_GAIN_MUTE);
		tx_gain_d = tx_amute_d ? LAPC_GAIN_0DB
			: lapc_gain_type'(audio_q[`LAPC_TX_GAIN_RANGE]);
		rx_amute_d = (audio_q[`LAPC_RX_GAIN_RANGE] == LAPC_GAIN_MUTE);
		rx_gain_d = rx_amute_d ? LAPC_GAIN_0DB
			: lapc_gain_type'(audio_q[`LAPC_RX_GAIN_RANGE]);
		// Reserved capacitance code is treated as off, a safe fallback
		cap_d = lapc_cap_type'(imped_q[`LAPC_CAP_RANGE]);
		if (cap_d == LAPC_CAP_RSVD) begin
			cap_d = LAPC_CAP_OFF;
		end
		synth_en_d = imped_q[`LAPC_SYNTH_EN_BIT];
		profile_d = imped_q[`LAPC_PROFILE_RANGE];
		onehot_d = onehot_c;
		meter_on_d = meter_on_c;
		meter_step_d = meter_step_c;
		audio_on_d = audio_on_c;
		audio_step_d = audio_step_c;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_byp_q <= 1'b0;
			tx_byp_q <= 1'b0;
			tx_dmute_q <= 1'b0;
			rx_dmute_q <= 1'b0;
			tx_gain_q <= LAPC_GAIN_0DB;
			tx_amute_q <= 1'b0;
			rx_gain_q <= LAPC_GAIN_0DB;
			rx_amute_q <= 1'b0;
			cap_q <= LAPC_CAP_OFF;
			synth_en_q <= 1'b0;
			profile_q <= 3'h0;
			onehot_q <= 8'h00;
			meter_on_q <= 1'b0;
			meter_step_q <= 3'h0;
			audio_on_q <= 1'b0;
			audio_step_q <= 3'h0;
		end else begin
			rx_byp_q <= rx_byp_d;
			tx_byp_q <= tx_byp_d;
			tx_dmute_q <= tx_dmute_d;
			rx_dmute_q <= rx_dmute_d;
			tx_gain_q <= tx_gain_d;
			tx_amute_q <= tx_amute_d;
			rx_gain_q <= rx_gain_d;
			rx_amute_q <= rx_amute_d;
			cap_q <= cap_d;
			synth_en_q <= synth_en_d;
			profile_q <= profile_d;
			onehot_q <= onehot_d;
			meter_on_q <= meter_on_d;
			meter_step_q <= meter_step_d;
			audio_on_q <= audio_on_d;
			audio_step_q <= audio_step_d;
		end
	end

	// ****************************************************************
	// Power overrides
	// ****************************************************************
	// A set force bit wins over the automatic request in every case
	always_comb begin
		conv_off_d = power_q[`LAPC_CONV_OFF_BIT];
		pll_force_d = power_q[`LAPC_PLL_FREE_BIT];
		bias_off_d = power_q[`LAPC_BIAS_OFF_BIT];
		line_off_d = power_q[`LAPC_LINE_OFF_BIT];
		conv_on_d = auto_converter_on && !conv_off_d;
		pll_free_d = auto_pll_freerun || pll_force_d;
		bias_on_d = auto_bias_on && !bias_off_d;
		line_on_d = auto_line_interface_on && !line_off_d;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_off_q <= 1'b0;
			pll_force_q <= 1'b0;
			bias_off_q <= 1'b0;
			line_off_q <= 1'b0;
			conv_on_q <= 1'b0;
			pll_free_q <= 1'b0;
			bias_on_q <= 1'b0;
			line_on_q <= 1'b0;
		end else begin
			conv_off_q <= conv_off_d;
			pll_force_q <= pll_force_d;
			bias_off_q <= bias_off_d;
			line_off_q <= line_off_d;
			conv_on_q <= conv_on_d;
			pll_free_q <= pll_free_d;
			bias_on_q <= bias_on_d;
			line_on_q <= line_on_d;
		end
	end

	// ****************************************************************
	// Output wiring
	// ****************************************************************
	// Every port below is a flip-flop output
	assign pready = pready_q;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;
	assign receive_filter_bypass = rx_byp_q;
	assign transmit_filter_bypass = tx_byp_q;
	assign transmit_digital_mute = tx_dmute_q;
	assign receive_digital_mute = rx_dmute_q;
	assign analog_tx_gain_sel = tx_gain_q;
	assign analog_tx_mute = tx_amute_q;
	assign analog_rx_gain_sel = rx_gain_q;
	assign analog_rx_mute = rx_amute_q;
	assign line_cap_comp_sel = cap_q;
	assign impedance_synth_enable = synth_en_q;
	assign impedance_profile_sel = profile_q;
	assign impedance_profile_onehot = onehot_q;
	assign metering_hybrid_on = meter_on_q;
	assign metering_hybrid_adjust = meter_step_q;
	assign audio_hybrid_on = audio_on_q;
	assign audio_hybrid_adjust = audio_step_q;
	assign converter_force_off = conv_off_q;
	assign pll_freerun_force = pll_force_q;
	assign bias_force_off = bias_off_q;
	assign line_interface_force_off = line_off_q;
	assign converter_power_on = conv_on_q;
	assign pll_freerun = pll_free_q;
	assign bias_power_on = bias_on_q;
	assign line_interface_power_on = line_on_q;

endmodule : lapc_regs

// file: verif/lapc_regs_assertions.sv
// Purpose: Concurrent checks on the ports of the line audio and power control bank.
// Assumes: Zero wait state APB slave; decoded outputs settle two edges after a write.
// Notes: Bound to lapc_regs below the module.
`include "lapc_defs.svh"

module lapc_regs_chk (
	input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
	input wire logic [`LAPC_AW-1:0] paddr,
	input wire logic [`LAPC_DW-1:0] pwdata, prdata,
	input wire logic [3:0] pstrb,
	input wire logic auto_converter_on, auto_pll_freerun, auto_bias_on, auto_line_interface_on,
	input wire logic receive_filter_bypass, transmit_filter_bypass, transmit_digital_mute,
	input wire logic receive_digital_mute, analog_tx_mute, analog_rx_mute, impedance_synth_enable,
	input wire lapc_pkg::lapc_gain_type analog_tx_gain_sel, analog_rx_gain_sel,
	input wire lapc_pkg::lapc_cap_type line_cap_comp_sel,
	input wire logic [2:0] impedance_profile_sel, metering_hybrid_adjust, audio_hybrid_adjust,
	input wire logic [7:0] impedance_profile_onehot,
	input wire logic metering_hybrid_on, audio_hybrid_on, converter_force_off, pll_freerun_force,
	input wire logic bias_force_off, line_interface_force_off, converter_power_on, pll_freerun,
	input wire logic bias_power_on, line_interface_power_on
);
	timeunit 1ns;
	timeprecision 1ns;
	import lapc_pkg::*;
	localparam logic [7:0] AUD = 8'h24, IMP = 8'h28, HYB = 8'h2C, PWR = 8'h38;
	logic wr_ok;

	// A write that really stores: access edge, lane 0 strobed, no error
	assign wr_ok = psel && penable && pready && pwrite && pstrb[0] && !pslverr;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_pready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("pready is not a one cycle answer to a setup");
	a_audio_flags: assert property (
		wr_ok && paddr == AUD |-> ##2 {receive_filter_bypass, transmit_filter_bypass,
		transmit_digital_mute, receive_digital_mute} == $past(pwdata[7:4], 2))
		else $error("audio flag outputs do not follow the written bits");
	a_tx_gain: assert property (
		wr_ok && paddr == AUD |-> ##2 {analog_tx_mute, analog_tx_gain_sel} ==
		(($past(pwdata[3:2], 2) == 2'h3) ? 3'h4 : {1'b0, $past(pwdata[3:2], 2)}))
		else $error("transmit gain decode wrong");
	a_rx_gain: assert property (
		wr_ok && paddr == AUD |-> ##2 {analog_rx_mute, analog_rx_gain_sel} ==
		(($past(pwdata[1:0], 2) == 2'h3) ? 3'h4 : {1'b0, $past(pwdata[1:0], 2)}))
		else $error("receive gain decode wrong");
	a_cap_sel: assert property (
		wr_ok && paddr == IMP |-> ##2 line_cap_comp_sel ==
		(($past(pwdata[5:4], 2) == 2'h3) ? 2'h0 : $past(pwdata[5:4], 2)))
		else $error("capacitance compensation decode wrong");
	a_profile_sel: assert property (
		wr_ok && paddr == IMP |-> ##2 impedance_synth_enable == $past(pwdata[3], 2)
		&& impedance_profile_sel == $past(pwdata[2:0], 2)
		&& impedance_profile_onehot == (8'h01 << $past(pwdata[2:0], 2)))
		else $error("impedance synthesis outputs wrong");
	a_meter_hybrid: assert property (
		wr_ok && paddr == HYB |-> ##2 {metering_hybrid_on, metering_hybrid_adjust} ==
		(($past(pwdata[6:4], 2) == 3'h7) ? 4'h0 : {1'b1, $past(pwdata[6:4], 2)}))
		else $error("metering hybrid decode wrong");
	a_audio_hybrid: assert property (
		wr_ok && paddr == HYB |-> ##2 {audio_hybrid_on, audio_hybrid_adjust} ==
		(($past(pwdata[2:0], 2) == 3'h7) ? 4'h0 : {1'b1, $past(pwdata[2:0], 2)}))
		else $error("audio hybrid decode wrong");
	a_force_bits: assert property (
		wr_ok && paddr == PWR |-> ##2 {converter_force_off, pll_freerun_force, bias_force_off,
		line_interface_force_off} == {$past(pwdata[4:3], 2), $past(pwdata[1:0], 2)})
		else $error("power override bits do not follow the write");
	// Skip the edge where a force bit moves, though the power path is registered on that same edge
	a_power_follow: assert property (
		$past(presetn) && $stable({converter_force_off, bias_force_off, line_interface_force_off})
		|-> converter_power_on == ($past(auto_converter_on) && !converter_force_off)
		&& bias_power_on == ($past(auto_bias_on) && !bias_force_off)
		&& line_interface_power_on == ($past(auto_line_interface_on) && !line_interface_force_off))
		else $error("power on outputs ignore automatic request or override");
	a_pll_follow: assert property (
		$past(presetn) && $stable(pll_freerun_force)
		|-> pll_freerun == ($past(auto_pll_freerun) || pll_freerun_force))
		else $error("pll free run output wrong");
	a_reserved_zero: assert property (
		pready && !pwrite |-> prdata[31:8] == 24'h0 && (!pslverr || prdata == 32'h0)
		&& (paddr != IMP || prdata[7:6] == 2'h0) && (paddr != HYB || !prdata[7] && !prdata[3])
		&& (paddr != PWR || prdata[7:5] == 3'h0 && !prdata[2]))
		else $error("reserved read bits not zero");

	// Main scenarios reached
	cover property (wr_ok && paddr == PWR);
	cover property (pready && pslverr);
	cover property (pll_freerun && !auto_pll_freerun);
endmodule : lapc_regs_chk

bind lapc_regs lapc_regs_chk lapc_regs_chk_inst (.*);

// file: verif/tb.sv
// Purpose: Self-checking bench for the line audio and power control bank.
// Assumes: pclk at 10 MHz, zero wait state APB slave.
// Notes: Register rows first, then strobe, refusal, override and reset cases.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import lapc_pkg::*;
	typedef struct {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rdata;} lapc_row_type;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic auto_converter_on, auto_pll_freerun, auto_bias_on, auto_line_interface_on;
	logic receive_filter_bypass, transmit_filter_bypass, transmit_digital_mute;
	logic receive_digital_mute, analog_tx_mute, analog_rx_mute, impedance_synth_enable;
	logic metering_hybrid_on, audio_hybrid_on, converter_force_off, pll_freerun_force;
	logic bias_force_off, line_interface_force_off, converter_power_on, pll_freerun;
	logic bias_power_on, line_interface_power_on;
	lapc_gain_type analog_tx_gain_sel, analog_rx_gain_sel;
	lapc_cap_type line_cap_comp_sel;
	logic [2:0] impedance_profile_sel, metering_hybrid_adjust, audio_hybrid_adjust;
	logic [7:0] impedance_profile_onehot;
	lapc_row_type rows [16];
	int failures, checks;

	lapc_regs lapc_regs_inst (.*);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	// One APB transfer; waits on pready, only the watchdog ends a hung wait
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic print_verdict();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict

	// Free-running clock, 100 ns period
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// Hang guard, far beyond the roughly 150 cycles the tests need
	initial begin
		repeat (3000) @(posedge pclk);
		failures++;
		print_verdict();
	end

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite} = 3'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'h0;
		{auto_converter_on, auto_pll_freerun, auto_bias_on, auto_line_interface_on} = 4'hB;
		rows = '{'{8'h24, 8'hE4, 8'hE4}, '{8'h24, 8'h1B, 8'h1B}, '{8'h24, 8'h0D, 8'h0D},
			'{8'h24, 8'h32, 8'h32}, '{8'h28, 8'hFF, 8'h3F}, '{8'h28, 8'h1A, 8'h1A},
			'{8'h28, 8'h25, 8'h25}, '{8'h28, 8'h30, 8'h30}, '{8'h2C, 8'hFF, 8'h77},
			'{8'h2C, 8'h60, 8'h60}, '{8'h2C, 8'h16, 8'h16}, '{8'h38, 8'hFF, 8'h1B},
			'{8'h38, 8'hE4, 8'h00}, '{8'h38, 8'h18, 8'h18}, '{8'h38, 8'h03, 8'h03},
			'{8'h38, 8'h00, 8'h00}};
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		// Every gain code but only some capacitance, profile and hybrid codes written, read back through the write mask
		foreach (rows[i]) begin
			apb(1'b1, rows[i].addr, {24'hA5A5A5, rows[i].wdata}, 4'hF);
			apb(1'b0, rows[i].addr, 32'h0, 4'h0);
			check("readback", {24'h0, rows[i].rdata}, rd);
		end
		$display("test table done");
		// Lane 0 not strobed: the earlier value must survive
		apb(1'b1, 8'h24, 32'h5A, 4'hF);
		apb(1'b1, 8'h24, 32'hFF, 4'hE);
		check("strobe response", 1'b0, err);
		apb(1'b0, 8'h24, 32'h0, 4'h0);
		check("strobe", 32'h5A, rd);
		check("audio flags", 4'h5, {receive_filter_bypass, transmit_filter_bypass,
			transmit_digital_mute, receive_digital_mute});
		check("gains", {LAPC_GAIN_P3P5, LAPC_GAIN_P3P5}, {analog_tx_gain_sel, analog_rx_gain_sel});
		$display("test strobe done");
		// Unmapped and unaligned accesses are refused and store nothing
		apb(1'b0, 8'h30, 32'h0, 4'h0);
		check("unmapped data", 32'h0, rd);
		check("unmapped error", 1'b1, err);
		apb(1'b1, 8'h25, 32'hFF, 4'hF);
		check("unaligned", 1'b1, err);
		apb(1'b0, 8'h24, 32'h0, 4'h0);
		check("after refusal", 32'h5A, rd);
		$display("test refusal done");
		// Overrides against automatic requests
		apb(1'b1, 8'h38, 32'h08, 4'hF);
		repeat (3) @(posedge pclk);
		check("pll forced", 4'hF, {converter_power_on, pll_freerun, bias_power_on,
			line_interface_power_on});
		apb(1'b1, 8'h38, 32'h13, 4'hF);
		repeat (3) @(posedge pclk);
		check("forced off", 4'h0, {converter_power_on, pll_freerun, bias_power_on,
			line_interface_power_on});
		// Overrides released: outputs must follow a changed automatic request
		{auto_converter_on, auto_pll_freerun, auto_bias_on, auto_line_interface_on} <= 4'h4;
		apb(1'b1, 8'h38, 32'h00, 4'hF);
		repeat (3) @(posedge pclk);
		check("automatic", 4'h4, {converter_power_on, pll_freerun, bias_power_on,
			line_interface_power_on});
		$display("test override done");
		// Reset in mid-run returns every register to zero
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		check("in reset", 9'h000, {impedance_profile_onehot, pll_freerun});
		presetn <= 1'b1;
		foreach (rows[i]) begin
			if (i % 4 == 0) begin
				apb(1'b0, rows[i].addr, 32'h0, 4'h0);
				check("reset value", 32'h0, rd);
			end
		end
		check("onehot", 8'h01, impedance_profile_onehot);
		check("hybrids on", 2'h3, {metering_hybrid_on, audio_hybrid_on});
		$display("test reset done");
		print_verdict();
	end
endmodule : tb
